/* design/rxpsm_pkg.sv */
// Package: register map, field positions, reset values and timing constants
package rxpsm_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_GEN_CFG = 8'h02;
  localparam logic [7:0] OFS_CAP_FLAGS = 8'h4a;
  localparam logic [7:0] OFS_PORT_SEL = 8'h4c;
  localparam logic [7:0] OFS_STS_FIRST = 8'h4d;
  localparam logic [7:0] OFS_STS_SECOND = 8'h4e;
  localparam logic [7:0] OFS_PAR_HI = 8'h55;
  localparam logic [7:0] OFS_PAR_LO = 8'h56;
  localparam logic [7:0] OFS_INFO_BASE = 8'h59;
  localparam logic [7:0] OFS_FREQ_CTL = 8'h77;
  localparam logic [7:0] OFS_FREQ_HI = 8'h78;
  localparam logic [7:0] OFS_FREQ_LO = 8'h79;
  localparam logic [7:0] OFS_PAR_THR = 8'h7c;
  localparam logic [7:0] OFS_ENC_CTL = 8'h8a;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_PAR_CHK_EN = 0;   // general_configuration
  localparam int BIT_PAR_KEEP = 2;     // general_configuration
  localparam int BIT_CRC_CAPABLE = 4;  // link_capability_flags
  localparam int BIT_CRC_OFF = 7;      // encoder control
  localparam int BIT_S1_LOCK = 0;
  localparam int BIT_S1_PAR_FLAG = 1;
  localparam int BIT_S1_LOCK_CHG = 2;
  localparam int BIT_S1_CRC_FLT = 3;
  localparam int BIT_S1_ORD_FLT = 4;
  localparam int BIT_S2_STABLE = 1;
  localparam int BIT_S2_NO_CLK = 2;
  localparam int BIT_S2_FREQ_CHG = 3;
  localparam int BIT_S2_ENC_FLT = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_GEN_CFG = 8'h01;
  localparam logic [7:0] RST_CAP_FLAGS = 8'h00;
  localparam logic [7:0] RST_FREQ_CTL = 8'h21;
  localparam logic [7:0] RST_PAR_THR = 8'h01;
  localparam logic [7:0] RST_ENC_CTL = 8'h80;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FREQ_WIN_NS = 1000;   // measurement window, well under 1 ms
  localparam int FREQ_WIN_CYC = FREQ_WIN_NS / CLK_PERIOD_NS;
  localparam int FREQ_WIN_W = 7;

endpackage

/* design/rxpsm_par_cnt.sv */
// Parity error counter with threshold flag and clear-on-read
`timescale 1ns/1ps
module rxpsm_par_cnt #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic par_evt,
  input wire logic clr,
  input wire logic [7:0] thresh,
  output logic [CNT_W-1:0] count_r,
  output logic flag_r,
  output logic flag_rise_r
);
  import rxpsm_pkg::*;

  logic [CNT_W-1:0] count_nxt;
  logic flag_nxt;

  // Next count: a new error in the clearing cycle is kept
  always_comb begin
    if (clr) begin
      count_nxt = par_evt ? CNT_W'(1) : '0;
    end else if (par_evt && count_r != {CNT_W{1'b1}}) begin
      count_nxt = count_r + CNT_W'(1);
    end else begin
      count_nxt = count_r;
    end
    flag_nxt = (thresh != 8'h00) && (count_nxt >= CNT_W'(thresh));
    if (!clr && flag_r) begin
      flag_nxt = 1'b1;
    end
  end

  // Counter and flag state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_r <= '0;
      flag_r <= 1'b0;
      flag_rise_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      flag_r <= flag_nxt;
      flag_rise_r <= flag_nxt & ~flag_r;
    end
  end

  a_par_count_up: assert property (@(posedge clk) disable iff (!rstn)
    par_evt && !clr && count_r < 16'h00ff |=> count_r == $past(count_r) + 1)
    else $error("parity counter did not advance");
  a_par_clear_read: assert property (@(posedge clk) disable iff (!rstn)
    clr && !par_evt |=> count_r == '0 && !flag_r)
    else $error("parity counter or flag not cleared");
  a_par_flag_irq: assert property (@(posedge clk) disable iff (!rstn)
    !flag_r ##1 flag_r |-> flag_rise_r)
    else $error("parity flag rise without event");
  a_par_thr_hit: assert property (@(posedge clk) disable iff (!rstn)
    count_r >= CNT_W'(thresh) && thresh != 8'h00 && !$past(clr) |-> flag_r)
    else $error("parity flag missing at threshold");

endmodule // rxpsm_par_cnt

/* design/rxpsm_freq_det.sv */
// Input clock frequency measurement, stability and no-clock detection
`timescale 1ns/1ps
module rxpsm_freq_det (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_tick,
  input wire logic [3:0] lo_thr,
  input wire logic [3:0] hyst,
  output logic [15:0] freq_r,
  output logic stable_r,
  output logic no_clk_r,
  output logic change_r
);
  import rxpsm_pkg::*;

  logic [FREQ_WIN_W-1:0] win_r;
  logic [15:0] cnt_r;
  logic win_end;
  logic moved;

  function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // Window end and change test against the last reading
  assign win_end = (win_r == FREQ_WIN_W'(FREQ_WIN_CYC - 1));
  assign moved = abs_diff(cnt_r, freq_r) > {12'h000, hyst};

  // Window timer and tick counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      win_r <= '0;
      cnt_r <= '0;
    end else begin
      win_r <= win_end ? '0 : win_r + FREQ_WIN_W'(1);
      if (win_end) begin
        cnt_r <= {15'h0000, clk_tick};
      end else if (clk_tick) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // Result registers refreshed once per window
  always_ff @(posedge clk) begin
    if (!rstn) begin
      freq_r <= '0;
      stable_r <= 1'b0;
      no_clk_r <= 1'b1;
      change_r <= 1'b0;
    end else begin
      change_r <= win_end && moved;
      if (win_end) begin
        freq_r <= cnt_r;
        no_clk_r <= cnt_r < {12'h000, lo_thr};
        stable_r <= !moved;
      end
    end
  end

  a_freq_refresh: assert property (@(posedge clk) disable iff (!rstn)
    win_r < FREQ_WIN_W'(FREQ_WIN_CYC))
    else $error("frequency window overran");
  a_no_clk_thr: assert property (@(posedge clk) disable iff (!rstn)
    win_end |=> no_clk_r == ($past(cnt_r) < {12'h000, $past(lo_thr)}))
    else $error("no-clock flag wrong after window");
  a_unstable_move: assert property (@(posedge clk) disable iff (!rstn)
    win_end && moved |=> !stable_r && change_r)
    else $error("frequency change not reported");

endmodule // rxpsm_freq_det

/* design/rxpsm_top.sv */
// Per-port receive status monitor with host register access
`timescale 1ns/1ps

// Summary of operation
// - Status captured into two registers 0x4D, 0x4E
// - Lock change, channel faults latched; clear on read
// - Parity errors counted in 16-bit hi/lo registers
// - Parity flag set at programmed count
// - Counter read zeroes counter and parity flag
// - Loss of lock clears counter and flag unless the parity keep bit is set
// - Parity flag assertion raises event
// - Encoding or sequence error latches encoder fault
// - Encoder fault assertion raises event
// - Encoder fault flag clears on read
// - Failed CRC packets never update link info while the CRC check is active
// - Stable and no-clock bits in status two
// - No-clock set below low rate threshold
// - Stable cleared when change exceeds hysteresis
// - 16-bit frequency refreshed well under 1 ms
// - Frequency change on any port raises event
module rxpsm_top #(
  parameter int NPORT = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [NPORT-1:0] lock_in,
  input wire logic [NPORT-1:0] ctrl_crc_err,
  input wire logic [NPORT-1:0] ctrl_order_err,
  input wire logic [NPORT-1:0] par_err,
  input wire logic [NPORT-1:0] enc_err,
  input wire logic [NPORT-1:0] seq_err,
  input wire logic [NPORT-1:0] info_valid,
  input wire logic [NPORT-1:0] info_crc_ok,
  input wire logic [1:0] info_sel,
  input wire logic [7:0] info_byte,
  input wire logic [NPORT-1:0] rx_clk_tick,
  output logic [NPORT-1:0] par_irq_evt,
  output logic [NPORT-1:0] enc_irq_evt,
  output logic [NPORT-1:0] freq_irq_evt
);
  import rxpsm_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] gen_cfg_r, cap_r, freq_ctl_r, par_thr_r, enc_ctl_r;
  logic port_sel_r;
  logic [NPORT-1:0] lock_q_r, lock_chg_r, crc_flt_r, ord_flt_r;
  logic [NPORT-1:0] enc_flt_r, freq_chg_r;
  logic [7:0] info_r [NPORT][3];
  logic [7:0] par_lo_snap_r;
  logic [7:0] rdata_nxt;
  logic [NPORT-1:0] rd_s1, rd_s2, rd_par, lock_evt, unlock, par_clr;
  logic [NPORT-1:0] par_gated, enc_evt, info_take;
  logic [15:0] par_cnt [NPORT];
  logic [15:0] freq_val [NPORT];
  logic [NPORT-1:0] par_flag, stable, no_clk, freq_evt;
  logic crc_active;

  // ---------------------------------------------------------------
  // Host access decode
  // ---------------------------------------------------------------
  function automatic logic is_read(input logic [7:0] ofs);
    is_read = reg_rd && (reg_addr == ofs);
  endfunction

  function automatic logic is_write(input logic [7:0] ofs);
    is_write = reg_wr && (reg_addr == ofs);
  endfunction

  // Per-port read strobes and event conditions
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      rd_s1[p] = is_read(OFS_STS_FIRST) && (port_sel_r == p[0]);
      rd_s2[p] = is_read(OFS_STS_SECOND) && (port_sel_r == p[0]);
      rd_par[p] = is_read(OFS_PAR_HI) && (port_sel_r == p[0]);
    end
  end

  assign lock_evt = lock_in ^ lock_q_r;
  assign unlock = lock_q_r & ~lock_in;
  assign par_clr = rd_par | (unlock & {NPORT{~gen_cfg_r[BIT_PAR_KEEP]}});
  assign par_gated = par_err & {NPORT{gen_cfg_r[BIT_PAR_CHK_EN]}};
  assign enc_evt = enc_err | seq_err;
  assign crc_active = ~enc_ctl_r[BIT_CRC_OFF] & cap_r[BIT_CRC_CAPABLE];
  assign info_take = info_valid & (info_crc_ok | {NPORT{~crc_active}});

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Host writable settings shared by both ports
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gen_cfg_r <= RST_GEN_CFG;
      cap_r <= RST_CAP_FLAGS;
      freq_ctl_r <= RST_FREQ_CTL;
      par_thr_r <= RST_PAR_THR;
      enc_ctl_r <= RST_ENC_CTL;
      port_sel_r <= 1'b0;
    end else begin
      if (is_write(OFS_GEN_CFG)) gen_cfg_r <= reg_wdata;
      if (is_write(OFS_CAP_FLAGS)) cap_r <= reg_wdata;
      if (is_write(OFS_FREQ_CTL)) freq_ctl_r <= reg_wdata;
      if (is_write(OFS_PAR_THR)) par_thr_r <= reg_wdata;
      if (is_write(OFS_ENC_CTL)) enc_ctl_r <= reg_wdata;
      if (is_write(OFS_PORT_SEL)) port_sel_r <= reg_wdata[0];
    end
  end

  // ---------------------------------------------------------------
  // Sticky status flags, one set per port
  // ---------------------------------------------------------------
  // Set wins over the clear of the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_q_r <= '0;
      lock_chg_r <= '0;
      crc_flt_r <= '0;
      ord_flt_r <= '0;
      enc_flt_r <= '0;
      freq_chg_r <= '0;
    end else begin
      lock_q_r <= lock_in;
      lock_chg_r <= lock_evt | (lock_chg_r & ~rd_s1);
      crc_flt_r <= ctrl_crc_err | (crc_flt_r & ~rd_s1);
      ord_flt_r <= ctrl_order_err | (ord_flt_r & ~rd_s1);
      enc_flt_r <= enc_evt | (enc_flt_r & ~rd_s2);
      freq_chg_r <= freq_evt | (freq_chg_r & ~rd_s2);
    end
  end

  // Event outputs toward the interrupt logic
  always_ff @(posedge clk) begin
    if (!rstn) begin
      enc_irq_evt <= '0;
      freq_irq_evt <= '0;
    end else begin
      enc_irq_evt <= enc_evt & (~enc_flt_r | rd_s2);
      freq_irq_evt <= freq_evt;
    end
  end

  // ---------------------------------------------------------------
  // Link information, guarded by the packet CRC check
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int p = 0; p < NPORT; p++) begin
        for (int k = 0; k < 3; k++) begin
          info_r[p][k] <= 8'h00;
        end
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (info_take[p] && info_sel != 2'd3) begin
          info_r[p][info_sel] <= info_byte;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-port counters and frequency meters
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    // Each port owns its counter and meter
    rxpsm_par_cnt #(.CNT_W(16)) u_par (
      .clk(clk),
      .rstn(rstn),
      .par_evt(par_gated[g]),
      .clr(par_clr[g]),
      .thresh(par_thr_r),
      .count_r(par_cnt[g]),
      .flag_r(par_flag[g]),
      .flag_rise_r(par_irq_evt[g])
    );

    rxpsm_freq_det u_freq (
      .clk(clk),
      .rstn(rstn),
      .clk_tick(rx_clk_tick[g]),
      .lo_thr(freq_ctl_r[3:0]),
      .hyst(freq_ctl_r[7:4]),
      .freq_r(freq_val[g]),
      .stable_r(stable[g]),
      .no_clk_r(no_clk[g]),
      .change_r(freq_evt[g])
    );
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Register read multiplexer for the selected port
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      OFS_GEN_CFG: rdata_nxt = gen_cfg_r;
      OFS_CAP_FLAGS: rdata_nxt = cap_r;
      OFS_PORT_SEL: rdata_nxt = {7'h00, port_sel_r};
      OFS_STS_FIRST: begin
        rdata_nxt[BIT_S1_LOCK] = lock_q_r[port_sel_r];
        rdata_nxt[BIT_S1_PAR_FLAG] = par_flag[port_sel_r];
        rdata_nxt[BIT_S1_LOCK_CHG] = lock_chg_r[port_sel_r];
        rdata_nxt[BIT_S1_CRC_FLT] = crc_flt_r[port_sel_r];
        rdata_nxt[BIT_S1_ORD_FLT] = ord_flt_r[port_sel_r];
      end
      OFS_STS_SECOND: begin
        rdata_nxt[BIT_S2_STABLE] = stable[port_sel_r];
        rdata_nxt[BIT_S2_NO_CLK] = no_clk[port_sel_r];
        rdata_nxt[BIT_S2_FREQ_CHG] = freq_chg_r[port_sel_r];
        rdata_nxt[BIT_S2_ENC_FLT] = enc_flt_r[port_sel_r];
      end
      OFS_PAR_HI: rdata_nxt = par_cnt[port_sel_r][15:8];
      OFS_PAR_LO: rdata_nxt = par_lo_snap_r;
      OFS_INFO_BASE: rdata_nxt = info_r[port_sel_r][0];
      OFS_INFO_BASE + 8'h01: rdata_nxt = info_r[port_sel_r][1];
      OFS_INFO_BASE + 8'h02: rdata_nxt = info_r[port_sel_r][2];
      OFS_FREQ_CTL: rdata_nxt = freq_ctl_r;
      OFS_FREQ_HI: rdata_nxt = freq_val[port_sel_r][15:8];
      OFS_FREQ_LO: rdata_nxt = freq_val[port_sel_r][7:0];
      OFS_PAR_THR: rdata_nxt = par_thr_r;
      OFS_ENC_CTL: rdata_nxt = enc_ctl_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data register and low byte snapshot taken with the high byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      par_lo_snap_r <= 8'h00;
    end else begin
      if (reg_rd) reg_rdata <= rdata_nxt;
      if (is_read(OFS_PAR_HI)) begin
        par_lo_snap_r <= par_cnt[port_sel_r][7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_sts2_read_with_event;
    rd_s2[0] && enc_evt[0];
  endsequence

  sequence s_info_rejected;
    crc_active && info_valid[0] && !info_crc_ok[0];
  endsequence

  a_lock_chg_set: assert property (@(posedge clk) disable iff (!rstn)
    lock_in[0] != lock_q_r[0] |=> lock_chg_r[0] [*1] ##0 lock_q_r[0] == $past(lock_in[0]))
    else $error("lock change not flagged");
  a_sts1_cor: assert property (@(posedge clk) disable iff (!rstn)
    rd_s1[0] && !lock_evt[0] && !ctrl_crc_err[0] && !ctrl_order_err[0]
    |=> !lock_chg_r[0] && !crc_flt_r[0] && !ord_flt_r[0])
    else $error("status one flags not cleared on read");
  a_set_wins_read: assert property (@(posedge clk) disable iff (!rstn)
    s_sts2_read_with_event |=> enc_flt_r[0])
    else $error("encoder fault lost on read");
  a_enc_latch_hold: assert property (@(posedge clk) disable iff (!rstn)
    enc_evt[0] ##1 !rd_s2[0] |=> enc_flt_r[0])
    else $error("encoder fault not held");
  a_enc_irq_pulse: assert property (@(posedge clk) disable iff (!rstn)
    enc_evt[0] && !enc_flt_r[0] |=> enc_irq_evt[0])
    else $error("encoder event output missing");
  a_crc_block_info: assert property (@(posedge clk) disable iff (!rstn)
    s_info_rejected |=> info_r[0][0] == $past(info_r[0][0]))
    else $error("link info updated from failed packet");
  a_unlock_clear: assert property (@(posedge clk) disable iff (!rstn)
    unlock[0] && !gen_cfg_r[BIT_PAR_KEEP] && !par_gated[0]
    |=> par_cnt[0] == 16'h0000 && !par_flag[0])
    else $error("parity state kept across loss of lock");

endmodule // rxpsm_top

/* verification/rxpsm_link_model.sv */
// Far-side link model: recovered input clock ticks for each receive port
`timescale 1ns/1ps
module rxpsm_link_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0][3:0] div,
  output logic [1:0] rx_clk_tick
);
  logic [3:0] cnt_r [2];

  // One tick every div cycles; a zero divider means the cable is silent
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (!rstn || div[p] == 4'h0) begin
        cnt_r[p] <= 4'h0;
        rx_clk_tick[p] <= 1'b0;
      end else if (cnt_r[p] >= div[p] - 4'h1) begin
        cnt_r[p] <= 4'h0;
        rx_clk_tick[p] <= 1'b1;
      end else begin
        cnt_r[p] <= cnt_r[p] + 4'h1;
        rx_clk_tick[p] <= 1'b0;
      end
    end
  end
endmodule // rxpsm_link_model

/* verification/rxpsm_top_tb_top.sv */
// Self-checking bench for the receive port status monitor
`timescale 1ns/1ps
module rxpsm_top_tb_top;
  import rxpsm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [1:0] lock_in = 2'h0;
  logic [4:0][1:0] ev = '0;
  logic [1:0] info_valid = 2'h0;
  logic [1:0] info_crc_ok = 2'h0;
  logic [1:0] info_sel = 2'h0;
  logic [7:0] info_byte = 8'h00;
  logic [1:0][3:0] div = '0;
  logic [1:0] tick;
  logic [1:0] par_irq;
  logic [1:0] enc_irq;
  logic [1:0] frq_irq;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n_par = 0;
  int n_enc = 0;
  int n_frq = 0;
  logic [7:0] d;
  logic [7:0] h;

  // ---------------------------------------------------------------
  // Design, far side and clock
  // ---------------------------------------------------------------
  rxpsm_top #(.NPORT(2)) i_rxpsm_top (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lock_in(lock_in),
    .ctrl_crc_err(ev[3]), .ctrl_order_err(ev[4]), .par_err(ev[0]),
    .enc_err(ev[1]), .seq_err(ev[2]), .info_valid(info_valid),
    .info_crc_ok(info_crc_ok), .info_sel(info_sel),
    .info_byte(info_byte), .rx_clk_tick(tick), .par_irq_evt(par_irq),
    .enc_irq_evt(enc_irq), .freq_irq_evt(frq_irq));
  rxpsm_link_model i_rxpsm_link_model (.clk(clk), .rstn(rstn),
    .div(div), .rx_clk_tick(tick));

  // Clock source
  initial begin
    forever #5 clk = ~clk;
  end

  // Event pulse tally on port 0 and hang guard
  always @(posedge clk) begin
    n_par <= n_par + int'(par_irq[0]);
    n_enc <= n_enc + int'(enc_irq[0]);
    n_frq <= n_frq + int'(frq_irq[0]);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 q = reg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Kind 0 parity, 1 encoding, 2 sequence, 3 ctrl crc, 4 ctrl order
  task automatic pulse(input int k, input int p);
    @(posedge clk);
    ev[k][p] <= 1'b1;
    @(posedge clk);
    ev <= '0;
  endtask

  task automatic end_sim();
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] a [7];
    logic [7:0] e [7];
    a = '{OFS_GEN_CFG, OFS_CAP_FLAGS, OFS_FREQ_CTL, OFS_ENC_CTL,
          OFS_PAR_THR, OFS_STS_FIRST, 8'h33};
    e = '{RST_GEN_CFG, RST_CAP_FLAGS, RST_FREQ_CTL, RST_ENC_CTL,
          RST_PAR_THR, 8'h00, 8'h00};
    wr(8'h33, 8'hff);
    wr(OFS_STS_FIRST, 8'hff);
    for (int i = 0; i < 7; i++) begin
      rd(a[i], d);
      chk("reset value", e[i], d);
    end
  endtask

  task automatic t_lock_faults();
    lock_in <= 2'h1;
    pulse(3, 0);
    pulse(4, 0);
    rd(OFS_STS_FIRST, d);
    chk("status one", 16'h001d, d);
    rd(OFS_STS_FIRST, d);
    chk("status one cleared", 16'h0001, d);
    @(posedge clk);
    reg_addr <= OFS_STS_FIRST;
    reg_rd <= 1'b1;
    ev[3][0] <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    ev <= '0;
    rd(OFS_STS_FIRST, d);
    chk("fault kept over clear", 16'h0001, d[3]);
  endtask

  task automatic t_parity();
    int base;
    base = n_par;
    for (int i = 0; i < 3; i++) pulse(0, 0);
    repeat (3) @(posedge clk);
    chk("parity event", 16'h0001, n_par - base);
    rd(OFS_STS_FIRST, d);
    chk("parity flag", 16'h0001, d[BIT_S1_PAR_FLAG]);
    wr(OFS_GEN_CFG, 8'h00);
    rd(OFS_PAR_HI, h);
    rd(OFS_PAR_LO, d);
    chk("parity count", 16'h0003, {h, d});
    wr(OFS_GEN_CFG, 8'h01);
    rd(OFS_STS_FIRST, d);
    chk("parity flag read", 16'h0000, d[BIT_S1_PAR_FLAG]);
    pulse(0, 0);
    pulse(0, 0);
    lock_in <= 2'h0;
    rd(OFS_STS_FIRST, d);
    chk("flag on unlock", 16'h0000, d[BIT_S1_PAR_FLAG]);
    rd(OFS_PAR_HI, h);
    rd(OFS_PAR_LO, d);
    chk("count on unlock", 16'h0000, {h, d});
    lock_in <= 2'h1;
    rd(OFS_STS_FIRST, d);
  endtask

  task automatic t_encoder();
    int base;
    for (int k = 1; k < 3; k++) begin
      base = n_enc;
      pulse(k, 0); // Lock held steady across the error
      repeat (2) @(posedge clk);
      chk("encoder event", 16'h0001, n_enc - base);
      rd(OFS_STS_SECOND, d);
      chk("encoder flag", 16'h0001, d[BIT_S2_ENC_FLT]);
      rd(OFS_STS_SECOND, d);
      chk("encoder clear", 16'h0000, d[BIT_S2_ENC_FLT]);
    end
    pulse(1, 1);
    rd(OFS_STS_SECOND, d);
    chk("port zero apart", 16'h0000, d[BIT_S2_ENC_FLT]);
    wr(OFS_PORT_SEL, 8'h01);
    rd(OFS_STS_SECOND, d);
    chk("port one flag", 16'h0001, d[BIT_S2_ENC_FLT]);
    wr(OFS_PORT_SEL, 8'h00);
  endtask

  task automatic send_info(input logic [7:0] v, input logic ok);
    @(posedge clk);
    info_sel <= 2'h0;
    info_byte <= v;
    info_crc_ok <= {1'b0, ok};
    info_valid <= 2'h1;
    @(posedge clk);
    info_valid <= 2'h0;
  endtask

  task automatic t_crc_gate();
    send_info(8'ha5, 1'b0);
    rd(OFS_INFO_BASE, d);
    chk("info crc off", 16'h00a5, d);
    wr(OFS_ENC_CTL, 8'h00);
    wr(OFS_CAP_FLAGS, 8'h10);
    send_info(8'h3c, 1'b0);
    rd(OFS_INFO_BASE, d);
    chk("info bad crc", 16'h00a5, d);
    send_info(8'h3c, 1'b1);
    rd(OFS_INFO_BASE, d);
    chk("info good crc", 16'h003c, d);
  endtask

  task automatic t_freq();
    int base;
    div[0] <= 4'h2;
    repeat (350) @(posedge clk);
    rd(OFS_STS_SECOND, d);
    chk("stable no clk", 16'h0001, d[2:1]);
    rd(OFS_FREQ_HI, h);
    rd(OFS_FREQ_LO, d);
    chk("freq value", 16'h0032, {h, d});
    base = n_frq;
    div[0] <= 4'h4;
    repeat (350) @(posedge clk);
    chk("freq event", 16'h0001, n_frq != base);
    rd(OFS_FREQ_LO, d);
    chk("freq new", 16'h0019, d);
    div[0] <= 4'h0;
    repeat (250) @(posedge clk);
    rd(OFS_STS_SECOND, d);
    chk("no clock", 16'h0001, d[BIT_S2_NO_CLK]);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_lock_faults();
    t_parity();
    t_encoder();
    t_crc_gate();
    t_freq();
    end_sim();
  end
endmodule // rxpsm_top_tb_top
